// file: logic/nested_irq_defines.vh
// register offsets, field positions, encodings and reset values of the nested interrupt controller
`ifndef NESTED_IRQ_DEFINES_VH
`define NESTED_IRQ_DEFINES_VH
`define OFS_PRIO0        12'h000
`define OFS_PRIO1        12'h004
`define OFS_PRIO2        12'h008
`define OFS_PRIO3        12'h00c
`define OFS_EXT_CTRL     12'h010
`define OFS_CPU_STATUS   12'h014
`define OFS_VECTOR       12'h018
`define PRIO_RESET       8'hff
`define PRIO3_RO_MASK    8'hf0
`define EXT_CTRL_RESET   8'h00
`define EXT_SENS_B_HI    7
`define EXT_SENS_B_LO    6
`define EXT_POL_B        5
`define EXT_SENS_A_HI    4
`define EXT_SENS_A_LO    3
`define EXT_POL_A        2
`define LVL_0            2'b10
`define LVL_1            2'b01
`define LVL_2            2'b00
`define LVL_3            2'b11
`define SENS_FALL_LOW    2'b00
`define SENS_RISE        2'b01
`define SENS_FALL        2'b10
`define SENS_BOTH        2'b11
`define NUM_SLOTS        14
`define VEC_SLOT0        16'hfffa
`define VEC_TRAP         16'hfffc
`define VEC_RESET        16'hfffe
`define SLOT_CLK         1
`define SLOT_EXT_A       2
`define SLOT_EXT_F       3
`define SLOT_EXT_BL      4
`define SLOT_EXT_BH      5
`define WAKE_HALT_MASK   14'h20bc
`define WAKE_ACTIVE_MASK 14'h20be
`endif

// file: logic/nested_irq_ctrl.v
// nested interrupt controller: priority registers, level tracking, external lines, arbitration
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "nested_irq_defines.vh"

module nested_irq_ctrl (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // apb slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output wire        o_pready,
    output wire        o_pslverr,
    output reg  [31:0] o_prdata,
    // cpu core events
    input  wire        i_instr_enable,
    input  wire        i_instr_disable,
    input  wire        i_instr_halt,
    input  wire        i_instr_wait,
    input  wire        i_instr_trap,
    input  wire        i_instr_return,
    input  wire        i_instr_pop_flags,
    input  wire [7:0]  i_pop_data,
    input  wire        i_service_ack,
    input  wire        i_active_halt,
    // interrupt sources
    input  wire [13:0] i_periph_req,
    input  wire [13:0] i_irq_enable,
    input  wire [3:0]  i_ext_line_a_low,
    input  wire [2:0]  i_ext_line_f_low,
    input  wire [3:0]  i_ext_line_b_low,
    input  wire [3:0]  i_ext_line_b_high,
    // outputs to cpu
    output reg  [7:0]  o_cpu_cond_code,
    output reg         o_irq_req,
    output reg  [15:0] o_irq_vector,
    output reg  [3:0]  o_irq_slot,
    output reg         o_wakeup,
    output wire        o_jump_if_level3,
    output wire        o_jump_if_not_level3
);
    // one-hot service states
    localparam ST_IDLE = 2'b01;
    localparam ST_SERV = 2'b10;

    reg  [7:0]  irq_priority_regs [0:3];
    reg  [7:0]  ext_irq_ctrl_reg;
    reg  [1:0]  state;
    reg  [3:0]  serv_slot;
    reg  [1:0]  serv_prio;
    reg  [3:0]  sync1;
    reg  [3:0]  sync2;
    reg  [3:0]  sync_prev;
    reg  [3:0]  ext_pending;
    reg  [3:0]  active_slot;
    reg         found;
    reg  [1:0]  best_prio;
    reg  [3:0]  best_slot;
    reg  [3:0]  ext_trig;
    reg  [3:0]  ext_level;
    reg  [7:0]  next_ext;
    integer     k;
    integer     j;
    integer     m;
    reg  [31:0] next_prdata;

    wire [1:0]  cur_level = {o_cpu_cond_code[5], o_cpu_cond_code[3]};
    wire        cur_level_hi = cur_level[1];
    wire        cur_level_lo = cur_level[0];
    wire        wr = i_psel & i_penable & i_pwrite;
    wire        rd = i_psel & i_penable & ~i_pwrite;
    wire [13:0] wake_mask = i_active_halt ? `WAKE_ACTIVE_MASK : `WAKE_HALT_MASK;

    assign o_pready  = 1'b1;
    assign o_pslverr = 1'b0;
    assign o_jump_if_level3     = cur_level_hi & cur_level_lo;
    assign o_jump_if_not_level3 = ~(cur_level_hi & cur_level_lo);

    // rank of a level code: 0 lowest .. 3 highest
    function [1:0] rank;
        input [1:0] code;
        begin
            case (code)
                `LVL_0:  rank = 2'd0;
                `LVL_1:  rank = 2'd1;
                `LVL_2:  rank = 2'd2;
                default: rank = 2'd3;
            endcase
        end
    endfunction

    // priority field of a slot
    function [1:0] slot_prio;
        input [3:0] s;
        reg   [7:0] r;
        begin
            r = irq_priority_regs[s[3:2]];
            slot_prio = r[2*s[1:0] +: 2];
        end
    endfunction

    // merge a written byte, keeping fields written with the forbidden pattern
    function [7:0] prio_merge;
        input [7:0] old;
        input [7:0] nw;
        integer f;
        begin
            prio_merge = nw;
            for (f = 0; f < 4; f = f + 1) begin
                if (nw[2*f +: 2] == `LVL_0) begin
                    prio_merge[2*f +: 2] = old[2*f +: 2];
                end
            end
        end
    endfunction

    // vector address of a maskable slot: two bytes per slot below slot 0
    function [15:0] slot_vector;
        input [3:0] s;
        begin
            slot_vector = `VEC_SLOT0 - {11'd0, s, 1'b0};
        end
    endfunction

    // sensitivity of one line: sens field, polarity, synced now and before
    function trig;
        input [1:0] sens;
        input       inv;
        input       now;
        input       prev;
        reg         rise;
        reg         fall;
        begin
            rise = now & ~prev;
            fall = ~now & prev;
            case (sens)
                `SENS_RISE: trig = inv ? fall : rise;
                `SENS_FALL: trig = inv ? rise : fall;
                `SENS_BOTH: trig = rise | fall;
                default:    trig = inv ? rise : fall;
            endcase
        end
    endfunction

    // external line synchroniser, one combined line per group
    always @(posedge i_clk) begin
        if (i_rst) begin
            sync1     <= 4'h0;
            sync2     <= 4'hf;
            sync_prev <= 4'hf;
        end else begin
            sync1     <= {~&i_ext_line_b_high, ~&i_ext_line_b_low, ~&i_ext_line_f_low, ~&i_ext_line_a_low};
            sync2     <= ~sync1;
            sync_prev <= sync2;
        end
    end

    // trigger and level detection per external slot; f and b high groups have no polarity inversion
    always @* begin
        ext_trig[0]  = trig(ext_irq_ctrl_reg[4:3], ext_irq_ctrl_reg[`EXT_POL_A], sync2[0], sync_prev[0]);
        ext_trig[1]  = trig(ext_irq_ctrl_reg[4:3], 1'b0, sync2[1], sync_prev[1]);
        ext_trig[2]  = trig(ext_irq_ctrl_reg[7:6], ext_irq_ctrl_reg[`EXT_POL_B], sync2[2], sync_prev[2]);
        ext_trig[3]  = trig(ext_irq_ctrl_reg[7:6], 1'b0, sync2[3], sync_prev[3]);
        ext_level[0] = (ext_irq_ctrl_reg[4:3] == `SENS_FALL_LOW) &
                       (sync2[0] == ext_irq_ctrl_reg[`EXT_POL_A]);
        ext_level[1] = (ext_irq_ctrl_reg[4:3] == `SENS_FALL_LOW) & ~sync2[1];
        ext_level[2] = (ext_irq_ctrl_reg[7:6] == `SENS_FALL_LOW) &
                       (sync2[2] == ext_irq_ctrl_reg[`EXT_POL_B]);
        ext_level[3] = (ext_irq_ctrl_reg[7:6] == `SENS_FALL_LOW) & ~sync2[3];
    end

    // control register write, allowed only at level 3
    always @* begin
        next_ext = ext_irq_ctrl_reg;
        if (wr && i_paddr == `OFS_EXT_CTRL && cur_level == `LVL_3) begin
            next_ext = {i_pwdata[7:2], 2'b00};
        end
    end

    // active request vector: peripherals plus external slots
    reg [13:0] req;
    always @* begin
        req = i_periph_req;
        req[0] = 1'b0;
        req[6] = 1'b0;
        for (j = 0; j < 4; j = j + 1) begin
            req[`SLOT_EXT_A + j] = ext_pending[j] | ext_level[j];
        end
    end

    // arbitration over enabled requests above the current level
    always @* begin
        found     = 1'b0;
        best_prio = 2'b00;
        best_slot = 4'd0;
        for (k = `NUM_SLOTS - 1; k >= 1; k = k - 1) begin
            if (req[k] && i_irq_enable[k] &&
                rank(slot_prio(k[3:0])) > rank(cur_level) &&
                (!found || rank(slot_prio(k[3:0])) >= rank(best_prio))) begin
                found     = 1'b1;
                best_prio = slot_prio(k[3:0]);
                best_slot = k[3:0];
            end
        end
        active_slot = best_slot;
    end

    // priority registers; a field written with the level 0 pattern is kept
    always @(posedge i_clk) begin
        if (i_rst) begin
            for (m = 0; m < 4; m = m + 1) begin
                irq_priority_regs[m] <= `PRIO_RESET;
            end
        end else if (wr) begin
            if (i_paddr == `OFS_PRIO0) begin
                irq_priority_regs[0] <= prio_merge(irq_priority_regs[0], i_pwdata[7:0]);
            end else if (i_paddr == `OFS_PRIO1) begin
                irq_priority_regs[1] <= prio_merge(irq_priority_regs[1], i_pwdata[7:0]);
            end else if (i_paddr == `OFS_PRIO2) begin
                irq_priority_regs[2] <= prio_merge(irq_priority_regs[2], i_pwdata[7:0]);
            end else if (i_paddr == `OFS_PRIO3) begin
                irq_priority_regs[3] <= prio_merge(irq_priority_regs[3], i_pwdata[7:0]) | `PRIO3_RO_MASK;
            end
        end
    end

    // pending latches: an edge in the same cycle beats either clear
    wire        ext_changed = (next_ext != ext_irq_ctrl_reg);
    wire        serv_done   = i_service_ack & (state == ST_SERV);
    wire [3:0]  next_pending;
    genvar      g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pend
            assign next_pending[g] = ext_trig[g] |
                                     (ext_pending[g] & ~ext_changed &
                                      ~(serv_done & (serv_slot == `SLOT_EXT_A + g)));
        end
    endgenerate

    // external control register and pending latches
    always @(posedge i_clk) begin
        if (i_rst) begin
            ext_irq_ctrl_reg <= `EXT_CTRL_RESET;
            ext_pending      <= 4'h0;
        end else begin
            ext_irq_ctrl_reg <= next_ext;
            ext_pending      <= next_pending;
        end
    end

    // current level bits: trap, then entry, then pop or return, then disable, then enable
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_cpu_cond_code <= 8'hfa;
        end else if (i_instr_trap) begin
            o_cpu_cond_code[5] <= 1'b1;
            o_cpu_cond_code[3] <= 1'b1;
        end else if (serv_done) begin
            o_cpu_cond_code[5] <= serv_prio[1];
            o_cpu_cond_code[3] <= serv_prio[0];
        end else if (i_instr_pop_flags || i_instr_return) begin
            o_cpu_cond_code <= i_pop_data | 8'hc0;
        end else if (i_instr_disable) begin
            o_cpu_cond_code[5] <= 1'b1;
            o_cpu_cond_code[3] <= 1'b1;
        end else if (i_instr_enable || i_instr_halt || i_instr_wait) begin
            o_cpu_cond_code[5] <= 1'b1;
            o_cpu_cond_code[3] <= 1'b0;
        end
    end

    // request to cpu; arbitration reruns each cycle so a raised field re-enters
    always @(posedge i_clk) begin
        if (i_rst) begin
            state        <= ST_IDLE;
            serv_slot    <= 4'd0;
            serv_prio    <= `LVL_3;
            o_irq_req    <= 1'b0;
            o_irq_vector <= `VEC_RESET;
            o_irq_slot   <= 4'd0;
        end else begin
            case (state)
                ST_IDLE: begin
                    o_irq_req <= found;
                    if (found) begin
                        state        <= ST_SERV;
                        serv_slot    <= active_slot;
                        serv_prio    <= best_prio;
                        o_irq_slot   <= active_slot;
                        o_irq_vector <= slot_vector(active_slot);
                    end
                end
                ST_SERV: begin
                    if (i_service_ack) begin
                        state     <= ST_IDLE;
                        o_irq_req <= 1'b0;
                    end else if (found && active_slot != serv_slot) begin
                        serv_slot    <= active_slot;
                        serv_prio    <= best_prio;
                        o_irq_slot   <= active_slot;
                        o_irq_vector <= slot_vector(active_slot);
                    end else if (!found) begin
                        state     <= ST_IDLE;
                        o_irq_req <= 1'b0;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // wake request and read data register
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_wakeup <= 1'b0;
            o_prdata <= 32'h0000_0000;
        end else begin
            o_wakeup <= |(req & i_irq_enable & wake_mask) | i_instr_trap;
            if (rd) begin
                o_prdata <= next_prdata;
            end
        end
    end

    // read multiplexer; unmapped offsets read zero
    always @* begin
        next_prdata = 32'h0000_0000;
        if (i_paddr == `OFS_PRIO0) begin
            next_prdata = {24'h0, irq_priority_regs[0]};
        end else if (i_paddr == `OFS_PRIO1) begin
            next_prdata = {24'h0, irq_priority_regs[1]};
        end else if (i_paddr == `OFS_PRIO2) begin
            next_prdata = {24'h0, irq_priority_regs[2]};
        end else if (i_paddr == `OFS_PRIO3) begin
            next_prdata = {24'h0, irq_priority_regs[3]};
        end else if (i_paddr == `OFS_EXT_CTRL) begin
            next_prdata = {24'h0, ext_irq_ctrl_reg};
        end else if (i_paddr == `OFS_CPU_STATUS) begin
            next_prdata = {20'h0, ext_pending, o_cpu_cond_code};
        end else if (i_paddr == `OFS_VECTOR) begin
            next_prdata = {16'h0, o_irq_vector};
        end else begin
            next_prdata = 32'h0000_0000;
        end
    end
endmodule // nested_irq_ctrl

// file: test/nested_irq_ctrl_chk.sv
// concurrent checks on the ports of the nested interrupt controller
`timescale 1ns/1ps
module nested_irq_chk (
    // clock and reset
    input wire        i_clk,
    input wire        i_rst,
    // cpu events
    input wire        i_instr_enable,
    input wire        i_instr_disable,
    input wire        i_instr_trap,
    input wire        i_instr_return,
    input wire        i_instr_pop_flags,
    input wire [7:0]  i_pop_data,
    input wire        i_service_ack,
    // controller outputs
    input wire [7:0]  o_cpu_cond_code,
    input wire        o_irq_req,
    input wire [15:0] o_irq_vector,
    input wire [3:0]  o_irq_slot,
    input wire        o_jump_if_level3,
    input wire        o_jump_if_not_level3
);
    wire [1:0] lvl;
    wire       upper;
    assign lvl   = {o_cpu_cond_code[5], o_cpu_cond_code[3]};
    assign upper = i_instr_trap | i_service_ack | i_instr_return | i_instr_pop_flags;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    trap_sets_lvl3_a: assert property (i_instr_trap |=> lvl == 2'b11)
        else $error("trap left level below 3");
    disable_lvl3_a: assert property (i_instr_disable && !upper |=> lvl == 2'b11)
        else $error("disable did not load level 3");
    enable_lvl0_a: assert property (i_instr_enable && !upper && !i_instr_disable |=> lvl == 2'b10)
        else $error("enable did not load level 0");
    pop_loads_a: assert property (i_instr_pop_flags && !i_instr_trap && !i_service_ack
        |=> o_cpu_cond_code == ($past(i_pop_data) | 8'hc0))
        else $error("flag pop mismatch");
    jump_level_a: assert property ({o_jump_if_level3, o_jump_if_not_level3} == {lvl == 2'b11, lvl != 2'b11})
        else $error("level jump outputs wrong");
    vector_slot_a: assert property (o_irq_req |-> o_irq_vector == 16'hfffa - {11'h000, o_irq_slot, 1'b0})
        else $error("vector does not match slot");
    unused_slot_a: assert property (o_irq_req |-> o_irq_slot != 4'h0 && o_irq_slot != 4'h6 && o_irq_slot < 4'he)
        else $error("request on unused slot");
    ack_level_a: assert property (i_service_ack && o_irq_req && !i_instr_trap |=> lvl != 2'b10)
        else $error("service entered at level 0");
    req_above_a: assert property ($rose(o_irq_req) |-> $past(lvl) != 2'b11)
        else $error("request raised at level 3");
    cover property (o_irq_req && i_service_ack);
    cover property (i_instr_trap);
    cover property (i_instr_pop_flags ##1 $rose(o_irq_req));
endmodule // nested_irq_chk
bind nested_irq_ctrl nested_irq_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_instr_enable(i_instr_enable),
    .i_instr_disable(i_instr_disable), .i_instr_trap(i_instr_trap), .i_instr_return(i_instr_return),
    .i_instr_pop_flags(i_instr_pop_flags), .i_pop_data(i_pop_data), .i_service_ack(i_service_ack),
    .o_cpu_cond_code(o_cpu_cond_code), .o_irq_req(o_irq_req), .o_irq_vector(o_irq_vector),
    .o_irq_slot(o_irq_slot), .o_jump_if_level3(o_jump_if_level3), .o_jump_if_not_level3(o_jump_if_not_level3));

// file: test/cpu_core_model.sv
// behavioural cpu core that enters service routines on request
`timescale 1ns/1ps
module cpu_core_model (
    // clock and reset
    input  wire       i_clk,
    input  wire       i_rst,
    // controller side
    input  wire       i_irq_req,
    input  wire [3:0] i_slow_cycles,
    output reg        o_service_ack
);
    reg [3:0] wait_cnt;
    // one ack pulse per request, only while it still stands
    always @(posedge i_clk) begin
        o_service_ack <= 1'b0;
        if (i_rst || !i_irq_req || o_service_ack) begin
            wait_cnt <= 4'h0;
        end else if (wait_cnt >= i_slow_cycles) begin
            o_service_ack <= 1'b1;
            wait_cnt      <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule // cpu_core_model

// file: test/tb_nested_interrupt_priority_ctrl.sv
// self-checking bench for the nested interrupt controller
`timescale 1ns/1ps
`include "nested_irq_defines.vh"
`define CHECK_EQ(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_nested_interrupt_priority_ctrl;
    reg         i_clk = 1'b0;
    reg         i_rst = 1'b1;
    reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0, seed = 32'h2d2c, q;
    reg  [6:0]  ins = 7'h00;
    reg  [7:0]  pop_d = 8'h00;
    reg  [13:0] periph = 14'h0000, en_mask = 14'h0000;
    reg  [3:0]  line_a = 4'hf, slow = 4'h0;
    reg  [7:0]  shadow [0:3];
    reg         lv3, ah = 1'b0;
    wire        pready, ack, irq, jm, jnm, wk, se;
    wire [31:0] prdata;
    wire [7:0]  cc;
    wire [15:0] vec;
    wire [3:0]  slot;
    integer     err_total = 0, num_checks = 0, i;
    always #12.5 i_clk = ~i_clk;
    nested_irq_ctrl dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(se), .o_prdata(prdata),
        .i_instr_enable(ins[0]), .i_instr_disable(ins[1]), .i_instr_halt(ins[2]), .i_instr_wait(ins[3]),
        .i_instr_trap(ins[4]), .i_instr_return(ins[5]), .i_instr_pop_flags(ins[6]), .i_pop_data(pop_d),
        .i_service_ack(ack), .i_active_halt(ah), .i_periph_req(periph), .i_irq_enable(en_mask),
        .i_ext_line_a_low(line_a), .i_ext_line_f_low(3'h7), .i_ext_line_b_low(4'hf), .i_ext_line_b_high(4'hf),
        .o_cpu_cond_code(cc), .o_irq_req(irq), .o_irq_vector(vec), .o_irq_slot(slot), .o_wakeup(wk),
        .o_jump_if_level3(jm), .o_jump_if_not_level3(jnm));
    cpu_core_model cpu (.i_clk(i_clk), .i_rst(i_rst), .i_irq_req(irq), .i_slow_cycles(slow), .o_service_ack(ack));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // a field written with the level 0 pattern keeps its old value
    function [7:0] merge(input [7:0] o, input [7:0] n, input top);
        integer k;
        begin
            for (k = 0; k < 4; k++) merge[2*k+:2] = (n[2*k+:2] == 2'b10) ? o[2*k+:2] : n[2*k+:2];
            if (top) merge[7:4] = 4'hf;
        end
    endfunction
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task apb(input w, input [11:0] a, input [7:0] d);
        integer n;
        begin
            @(posedge i_clk);
            psel   <= 1'b1;
            pwrite <= w;
            paddr  <= a;
            pwdata <= {24'h0, d};
            @(posedge i_clk);
            penable <= 1'b1;
            n = 0;
            @(posedge i_clk);
            while (pready !== 1'b1 && n < 50) begin
                @(posedge i_clk);
                n++;
            end
            if (n == 50) begin err_total++; finish_test; end
            psel    <= 1'b0;
            penable <= 1'b0;
            #1 q = prdata;
        end
    endtask
    task instr(input [2:0] k, input [7:0] d);
        begin
            @(posedge i_clk);
            ins   <= 7'h01 << k;
            pop_d <= d;
            @(posedge i_clk);
            ins <= 7'h00;
            #1;
        end
    endtask
    task wait_irq(input [3:0] s, input [1:0] lv);
        integer n;
        begin
            n = 0;
            while (irq !== 1'b1 && n < 40) begin @(posedge i_clk); #1 n++; end
            `CHECK_EQ("irq_slot", s, slot)
            `CHECK_EQ("irq_vector", 16'hfffa - {s, 1'b0}, vec)
            while (ack !== 1'b1 && n < 80) begin @(posedge i_clk); #1 n++; end
            @(posedge i_clk);
            #1 `CHECK_EQ("entry_level", lv, {cc[5], cc[3]})
            if (n >= 80) begin err_total++; finish_test; end
        end
    endtask
    task pin_edge;
        begin
            line_a <= 4'he;
            repeat (6) @(posedge i_clk);
            line_a <= 4'hf;
            repeat (6) @(posedge i_clk);
        end
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        #1 `CHECK_EQ("cc_reset", 8'hfa, cc)
        apb(1, 12'h000, 8'haa);
        for (i = 0; i < 4; i++) begin
            apb(0, {8'h0, i[1:0], 2'b00}, 8'h00);
            `CHECK_EQ("prio_reset", 32'hff, q)
            shadow[i] = 8'hff;
        end
        apb(0, 12'h01c, 8'h00);
        `CHECK_EQ("unmapped", 32'h0, q)
        `CHECK_EQ("pslverr", 1'b0, se)
        for (i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            apb(1, {8'h0, seed[3:2], 2'b00}, seed[15:8]);
            shadow[seed[3:2]] = merge(shadow[seed[3:2]], seed[15:8], seed[3:2] == 2'd3);
            apb(0, {8'h0, seed[3:2], 2'b00}, 8'h00);
            `CHECK_EQ("prio_rw", {24'h0, shadow[seed[3:2]]}, q)
        end
        for (i = 0; i < 5; i++) begin
            lv3 = (i == 1 || i == 4);
            instr(lv3 ? 3'd0 : 3'd1, 8'h00);
            instr(i[2:0], 8'h00);
            `CHECK_EQ("level", lv3 ? 2'b11 : 2'b10, {cc[5], cc[3]})
            `CHECK_EQ("jumps", {lv3, !lv3}, {jm, jnm})
        end
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            instr(3'd6, seed[7:0]);
            `CHECK_EQ("pop_flags", seed[7:0] | 8'hc0, cc)
        end
        apb(1, 12'h000, 8'hff);
        apb(1, 12'h004, 8'h7f);
        apb(1, 12'h008, 8'hf4);
        instr(3'd0, 8'h00);
        en_mask <= 14'h0384;
        periph  <= 14'h0380;
        wait_irq(4'd8, 2'b00);
        repeat (5) @(posedge i_clk);
        `CHECK_EQ("held_pending", 1'b0, irq)
        periph <= 14'h0280;
        instr(3'd5, 8'he2);
        wait_irq(4'd7, 2'b01);
        periph <= 14'h0200;
        slow   <= 4'h3;
        instr(3'd5, 8'he2);
        wait_irq(4'd9, 2'b01);
        `CHECK_EQ("wake_off", 1'b0, wk)
        periph <= 14'h0000;
        apb(1, `OFS_EXT_CTRL, 8'h10);
        apb(0, `OFS_EXT_CTRL, 8'h00);
        `CHECK_EQ("ext_locked", 32'h0, q)
        instr(3'd1, 8'h00);
        apb(1, `OFS_EXT_CTRL, 8'h10);
        apb(0, `OFS_EXT_CTRL, 8'h00);
        `CHECK_EQ("ext_ctrl", 32'h10, q)
        pin_edge;
        apb(0, `OFS_CPU_STATUS, 8'h00);
        `CHECK_EQ("ext_pending", 4'h1, q[11:8])
        apb(1, `OFS_EXT_CTRL, 8'h18);
        apb(0, `OFS_CPU_STATUS, 8'h00);
        `CHECK_EQ("pend_cleared", 4'h0, q[11:8])
        pin_edge;
        #1 `CHECK_EQ("wake_on", 1'b1, wk)
        instr(3'd0, 8'h00);
        wait_irq(4'd2, 2'b11);
        apb(0, `OFS_CPU_STATUS, 8'h00);
        `CHECK_EQ("ack_cleared", 4'h0, q[11:8])
        @(posedge i_clk);
        en_mask <= 14'h0002;
        periph  <= 14'h0002;
        repeat (3) @(posedge i_clk);
        #1 `CHECK_EQ("wake_halt", 1'b0, wk)
        @(posedge i_clk);
        ah <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1 `CHECK_EQ("wake_active", 1'b1, wk)
        finish_test;
    end
endmodule // tb_nested_interrupt_priority_ctrl
